/* File: logic/rtmc_handler.sv */
// mode code handler of the simulated remote terminals
//
// How it works
// - each terminal enables 32 receive and 32 transmit mode codes separately.
// - newer revision: mode commands on subaddress 0 and 31 are equal.
// - older revision: only subaddress 0 carries received mode commands.
// - last sent status kept per terminal; returned on transmit status.
// - broadcast before: broadcast bit set in status for status/last command.
// - last command kept per terminal; sent as data after status.
// - broadcast before: returned last command comes from terminal 31.
// - transmitter shutdown disables the alternate bus of that terminal.
// - broadcast shutdown via terminal 31 disables alternate bus for all.
// - override shutdown re-enables alternate bus, for all if broadcast.
// - reset terminal re-enables both buses, for all if broadcast.
// - mailbox monitoring terminals get no automatic handling of directed mode codes; broadcasts via terminal 31 still reach them.
// - codes 0-15 carry no data, 16-31 one; some codes refuse broadcast.
// - terminal 31 must be enabled; automatic handling applies to it too.
// - busy or message error: status only, no data moved.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "rtmc_defs.svh"
module rtmc_handler (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command words from the bus receiver
  input wire logic cmdValid,
  input wire rtmc_pkg::rtmc_word_t cmdWord,
  input wire logic cmdBus,
  // response to the bus transmitter
  output logic rspValid,
  output rtmc_pkg::rtmc_word_t rspStatus,
  output logic rspDataValid,
  output rtmc_pkg::rtmc_word_t rspData,
  // per terminal transmitter enables
  output logic [31:0] txEnA,
  output logic [31:0] txEnB,
  // interrupt
  output logic irq
);
  import rtmc_pkg::*;

  function automatic logic [31:0] oneHot(input logic [4:0] i);
    return 32'h00000001 << i;
  endfunction

  rtmc_dec_if dif();

  logic ctrlRevB;
  logic [4:0] termSel;
  logic [31:0] termEn;
  logic [31:0] mailbox;
  logic [31:0] bcastFlag;
  logic [31:0] rxMcEn [32];
  logic [31:0] txMcEn [32];
  rtmc_word_t statusBase [32];
  rtmc_word_t lastSent [32];
  rtmc_word_t lastCmd [32];
  logic [`RTMC_IRQ_W-1:0] irqStat;
  logic [`RTMC_IRQ_W-1:0] irqMask;
  logic [`RTMC_IRQ_W-1:0] irqClrMask;
  rtmc_word_t swCmd;

  assign dif.cmdWord = cmdWord;
  assign dif.revB = ctrlRevB;

  rtmc_decode u_dec (
    .bus(dif)
  );

  // command path
  wire [4:0] rt = dif.rt;
  wire mcEnabled = dif.isTx ? txMcEn[rt][dif.mc] : rxMcEn[rt][dif.mc];
  wire cmdHit = cmdValid && termEn[rt];
  wire mcTaken = cmdHit && dif.isMode && mcEnabled;
  wire illegalBc = mcTaken && dif.isBcast && !dif.bcastOk;
  wire modeOk = mcTaken && !illegalBc;
  // automatic handling only under the newer revision, never in mailbox mode
  wire autoOn = ctrlRevB && !mailbox[rt];
  wire autoHit = modeOk && autoOn && dif.act != RTMC_ACT_NONE;
  wire swHit = modeOk && !autoHit;
  wire plainHit = cmdHit && !dif.isMode;
  wire accepted = plainHit || modeOk;
  wire statHit = autoHit && dif.act == RTMC_ACT_STATUS;
  wire lastHit = autoHit && dif.act == RTMC_ACT_LASTCMD;
  wire shutHit = autoHit && dif.act == RTMC_ACT_SHUT;
  wire ovrdHit = autoHit && dif.act == RTMC_ACT_OVRD;
  wire rstHit = autoHit && dif.act == RTMC_ACT_RESET;

  // bit 4 is zero in a live status; a returned status shows the current broadcast mark, never a stored copy of it
  wire [31:0] bcBitWide = oneHot(`RTMC_STS_BCAST);
  wire rtmc_word_t bcBit = bcBitWide[15:0];
  wire rtmc_word_t stsNow = {rt, statusBase[rt][10:0]} & ~bcBit;
  wire rtmc_word_t stsPrev = bcastFlag[rt] ?
    (lastSent[rt] | bcBit) : (lastSent[rt] & ~bcBit);
  wire rtmc_word_t stsTx = (statHit || lastHit) ? stsPrev : stsNow;
  wire busyFlag = statusBase[rt][`RTMC_STS_BUSY] ||
                  statusBase[rt][`RTMC_STS_MERR];
  wire [4:0] srcRt = bcastFlag[rt] ? `RTMC_RT_BCAST : rt;
  wire busOk = cmdBus ? txEnB[rt] : txEnA[rt];
  // broadcast commands never get a status reply
  wire respond = accepted && !dif.isBcast && busOk;
  wire sendData = respond && lastHit && !busyFlag;
  // the two read-back codes must not overwrite what they return
  wire storeCmd = accepted && !statHit && !lastHit;

  wire [31:0] tgtMask = dif.isBcast ? 32'hffffffff : oneHot(rt);
  // alternate bus is the one the command did not arrive on
  wire [31:0] next_txEnA =
    (rstHit || (ovrdHit && cmdBus)) ? (txEnA | tgtMask) :
    (shutHit && cmdBus) ? (txEnA & ~tgtMask) : txEnA;
  wire [31:0] next_txEnB =
    (rstHit || (ovrdHit && !cmdBus)) ? (txEnB | tgtMask) :
    (shutHit && !cmdBus) ? (txEnB & ~tgtMask) : txEnB;
  wire [31:0] next_bcastFlag = !accepted ? bcastFlag :
    dif.isBcast ? 32'hffffffff : (bcastFlag & ~oneHot(rt));

  // apb decode
  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire wrEn = access && pwrite;
  wire rdEn = access && !pwrite;
  wire selCtrl = paddr == `RTMC_OFF_CTRL;
  wire selTermSel = paddr == `RTMC_OFF_TERM_SEL;
  wire selCfg = paddr == `RTMC_OFF_TERM_CFG;
  wire selRxEn = paddr == `RTMC_OFF_RX_MC_EN;
  wire selTxEn = paddr == `RTMC_OFF_TX_MC_EN;
  wire selSts = paddr == `RTMC_OFF_STS_BASE;
  wire selLastSts = paddr == `RTMC_OFF_LAST_STS;
  wire selLastCmd = paddr == `RTMC_OFF_LAST_CMD;
  wire selTxOn = paddr == `RTMC_OFF_TX_EN;
  wire selIrqStat = paddr == `RTMC_OFF_IRQ_STAT;
  wire selIrqMask = paddr == `RTMC_OFF_IRQ_MASK;
  wire selSwCmd = paddr == `RTMC_OFF_SW_CMD;
  wire mapped = selCtrl || selTermSel || selCfg || selRxEn || selTxEn ||
                selSts || selLastSts || selLastCmd || selTxOn ||
                selIrqStat || selIrqMask || selSwCmd;
  wire [31:0] rdMux =
    selCtrl ? {31'h0, ctrlRevB} :
    selTermSel ? {27'h0, termSel} :
    selCfg ? {30'h0, mailbox[termSel], termEn[termSel]} :
    selRxEn ? rxMcEn[termSel] :
    selTxEn ? txMcEn[termSel] :
    selSts ? {16'h0, statusBase[termSel]} :
    selLastSts ? {16'h0, lastSent[termSel]} :
    selLastCmd ? {16'h0, lastCmd[termSel]} :
    selTxOn ? {30'h0, txEnB[termSel], txEnA[termSel]} :
    selIrqStat ? {29'h0, irqStat} :
    selIrqMask ? {29'h0, irqMask} :
    selSwCmd ? {16'h0, swCmd} : 32'h0;

  wire [`RTMC_IRQ_W-1:0] evt = {illegalBc, autoHit, swHit};
  // only bits that were returned by the read are cleared; a set wins
  wire [`RTMC_IRQ_W-1:0] next_irqStat =
    (irqStat & ~((rdEn && selIrqStat) ? irqClrMask : 3'h0)) | evt;

  // apb slave: no wait state, data is registered in the setup cycle
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      irqClrMask <= 3'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup) begin
        prdata <= rdMux;
        irqClrMask <= irqStat;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrlRevB <= `RTMC_RST_REVB;
      termSel <= 5'h00;
      termEn <= 32'h0;
      mailbox <= 32'h0;
      irqMask <= 3'h0;
    end else if (wrEn) begin
      if (selCtrl) ctrlRevB <= pwdata[`RTMC_CTRL_REVB];
      if (selTermSel) termSel <= pwdata[4:0];
      if (selCfg) termEn[termSel] <= pwdata[`RTMC_CFG_ENABLE];
      if (selCfg) mailbox[termSel] <= pwdata[`RTMC_CFG_MAILBOX];
      if (selIrqMask) irqMask <= pwdata[`RTMC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < 32; i++) begin
        rxMcEn[i] <= 32'h0;
        txMcEn[i] <= 32'h0;
        statusBase[i] <= 16'h0;
      end
    end else if (wrEn) begin
      if (selRxEn) rxMcEn[termSel] <= pwdata;
      if (selTxEn) txMcEn[termSel] <= pwdata;
      if (selSts) statusBase[termSel] <= pwdata[15:0];
    end
  end

  // terminal state updated by commands
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < 32; i++) begin
        lastSent[i] <= 16'h0;
        lastCmd[i] <= 16'h0;
      end
    end else begin
      if (respond) lastSent[rt] <= stsTx;
      if (storeCmd) lastCmd[rt] <= cmdWord;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      txEnA <= `RTMC_RST_TXEN;
      txEnB <= `RTMC_RST_TXEN;
      bcastFlag <= 32'h0;
    end else begin
      txEnA <= next_txEnA;
      txEnB <= next_txEnB;
      bcastFlag <= next_bcastFlag;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rspValid <= 1'b0;
      rspStatus <= 16'h0;
      rspDataValid <= 1'b0;
      rspData <= 16'h0;
    end else begin
      rspValid <= respond;
      rspDataValid <= sendData;
      if (respond) rspStatus <= stsTx;
      if (respond) rspData <= lastCmd[srcRt];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irqStat <= 3'h0;
      irq <= 1'b0;
      swCmd <= 16'h0;
    end else begin
      irqStat <= next_irqStat;
      irq <= |(next_irqStat & irqMask);
      if (swHit) swCmd <= cmdWord;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence sqShutOnA;
    shutHit && !dif.isBcast && !cmdBus;
  endsequence
  sequence sqShutAll;
    shutHit && dif.isBcast;
  endsequence
  sequence sqLastCmdClean;
    lastHit && respond && !busyFlag;
  endsequence
  sequence sqLastAfterBcast;
    sqLastCmdClean ##0 bcastFlag[rt];
  endsequence

  a_mc_disabled_silent: assert property (
    cmdValid && dif.isMode && !mcEnabled && !dif.isBcast |=> !rspValid)
    else $error("disabled mode code was answered");
  a_sa31_rev_a: assert property (
    !ctrlRevB && dif.sa == `RTMC_SA_MODE31 |-> !dif.isMode)
    else $error("subaddress 31 taken as mode in older revision");
  a_sa31_rev_b: assert property (
    ctrlRevB && dif.sa == `RTMC_SA_MODE31 |-> dif.isMode)
    else $error("subaddress 31 not a mode in newer revision");
  a_status_bcast_bit: assert property (
    statHit && respond && bcastFlag[rt]
    |=> rspValid && rspStatus[`RTMC_STS_BCAST])
    else $error("broadcast bit missing in returned status");
  a_lastcmd_data: assert property (
    sqLastCmdClean |=> rspDataValid && rspData == $past(lastCmd[srcRt]))
    else $error("last command word not returned");
  a_shut_alt_bus: assert property (
    sqShutOnA |=> !txEnB[$past(rt)] && txEnA == $past(txEnA))
    else $error("shutdown did not disable only the alternate bus");
  a_shut_all_terms: assert property (
    sqShutAll |=> ($past(cmdBus) ? txEnA : txEnB) == 32'h0)
    else $error("broadcast shutdown missed a terminal");
  a_reset_both_bus: assert property (
    rstHit && !dif.isBcast |=> txEnA[$past(rt)] && txEnB[$past(rt)])
    else $error("reset terminal left a bus disabled");
  a_mailbox_no_auto: assert property (
    cmdValid && mailbox[rt] |-> !autoHit)
    else $error("automatic handling in mailbox mode");
  a_busy_no_data: assert property (
    cmdValid && busyFlag && !dif.isBcast |=> !rspDataValid)
    else $error("data sent while busy or message error");
  a_bcast_mark_clear: assert property (
    accepted && !dif.isBcast |=> !bcastFlag[$past(rt)])
    else $error("broadcast mark kept after directed transfer");
  a_illegal_bc_irq: assert property (
    illegalBc |=> irqStat[`RTMC_IRQ_BADBC] && !rspValid)
    else $error("illegal broadcast not flagged");
  a_ovrd_alt_bus: assert property (
    ovrdHit && !dif.isBcast && !cmdBus |=> txEnB[$past(rt)] && txEnA == $past(txEnA))
    else $error("override did not re-enable the alternate bus");
  a_ovrd_all_terms: assert property (
    ovrdHit && dif.isBcast |=> ($past(cmdBus) ? txEnA : txEnB) == 32'hffffffff)
    else $error("broadcast override missed a terminal");
  a_reset_all_terms: assert property (
    rstHit && dif.isBcast |=> (txEnA & txEnB) == 32'hffffffff)
    else $error("broadcast reset left a bus disabled");
  a_status_no_data: assert property (
    statHit && respond |=> rspValid && !rspDataValid)
    else $error("status return not sent alone");
  a_lastcmd_bcast_src: assert property (
    sqLastAfterBcast |=> rspData == $past(lastCmd[`RTMC_RT_BCAST]))
    else $error("last command not taken from broadcast terminal");
  a_bcast_no_reply: assert property (
    cmdValid && dif.isBcast |=> !rspValid)
    else $error("broadcast command was answered");
  a_sw_code_event: assert property (
    swHit |=> irqStat[`RTMC_IRQ_SW])
    else $error("software mode code not flagged");
  a_disabled_no_action: assert property (
    cmdValid && dif.isMode && !mcEnabled |-> !autoHit && !swHit)
    else $error("disabled mode code was acted on");
  a_bcast_mark_set: assert property (
    accepted && dif.isBcast |=> &bcastFlag)
    else $error("broadcast mark not set for all terminals");
  a_data_with_status: assert property (
    rspDataValid |-> rspValid)
    else $error("data word sent without status word");
endmodule

/* File: inc/rtmc_defs.svh */
// register offsets, field positions and mode code values of the handler
`ifndef RTMC_DEFS_SVH
`define RTMC_DEFS_SVH

`define RTMC_OFF_CTRL 12'h000
`define RTMC_OFF_TERM_SEL 12'h004
`define RTMC_OFF_TERM_CFG 12'h008
`define RTMC_OFF_RX_MC_EN 12'h00c
`define RTMC_OFF_TX_MC_EN 12'h010
`define RTMC_OFF_STS_BASE 12'h014
`define RTMC_OFF_LAST_STS 12'h018
`define RTMC_OFF_LAST_CMD 12'h01c
`define RTMC_OFF_TX_EN 12'h020
`define RTMC_OFF_IRQ_STAT 12'h024
`define RTMC_OFF_IRQ_MASK 12'h028
`define RTMC_OFF_SW_CMD 12'h02c

`define RTMC_CTRL_REVB 0
`define RTMC_CFG_ENABLE 0
`define RTMC_CFG_MAILBOX 1

`define RTMC_STS_MERR 10
`define RTMC_STS_BCAST 4
`define RTMC_STS_BUSY 3

`define RTMC_IRQ_SW 0
`define RTMC_IRQ_AUTO 1
`define RTMC_IRQ_BADBC 2
`define RTMC_IRQ_W 3

`define RTMC_SA_MODE0 5'h00
`define RTMC_SA_MODE31 5'h1f
`define RTMC_RT_BCAST 5'h1f

`define RTMC_MC_DYNBUS 5'h00
`define RTMC_MC_TXSTAT 5'h02
`define RTMC_MC_SHUT 5'h04
`define RTMC_MC_OVRD 5'h05
`define RTMC_MC_RESET 5'h08
`define RTMC_MC_VECTOR 5'h10
`define RTMC_MC_LASTCMD 5'h12
`define RTMC_MC_BITWORD 5'h13
`define RTMC_MC_DATA_BIT 4

`define RTMC_RST_REVB 1'h1
`define RTMC_RST_TXEN 32'hffffffff

`endif

/* File: inc/rtmc_pkg.sv */
// types shared by the mode code handler and its decoder
package rtmc_pkg;
  typedef enum logic [2:0] {
    RTMC_ACT_NONE = 3'b000,
    RTMC_ACT_STATUS = 3'b001,
    RTMC_ACT_LASTCMD = 3'b010,
    RTMC_ACT_SHUT = 3'b011,
    RTMC_ACT_OVRD = 3'b100,
    RTMC_ACT_RESET = 3'b101
  } rtmc_act_e;
  typedef logic [15:0] rtmc_word_t;
endpackage

/* File: inc/rtmc_dec_if.sv */
// command word and its decoded fields between handler and decoder
`timescale 1ns/100ps
interface rtmc_dec_if;
  import rtmc_pkg::*;
  rtmc_word_t cmdWord;
  logic revB;
  logic [4:0] rt;
  logic [4:0] sa;
  logic [4:0] mc;
  logic isTx;
  logic isMode;
  logic isBcast;
  logic hasData;
  logic bcastOk;
  rtmc_act_e act;
  modport dec (
    input cmdWord, revB,
    output rt, sa, mc, isTx, isMode, isBcast, hasData, bcastOk, act
  );
  modport user (
    output cmdWord, revB,
    input rt, sa, mc, isTx, isMode, isBcast, hasData, bcastOk, act
  );
endinterface

/* File: logic/rtmc_decode.sv */
// combinational decoder for a bus command word
`timescale 1ns/100ps
`include "rtmc_defs.svh"
module rtmc_decode (
  // decoded command
  rtmc_dec_if.dec bus
);
  import rtmc_pkg::*;

  function automatic logic bcastAllowed(input logic [4:0] code);
    return !(code == `RTMC_MC_DYNBUS || code == `RTMC_MC_TXSTAT ||
             code == `RTMC_MC_VECTOR || code == `RTMC_MC_LASTCMD ||
             code == `RTMC_MC_BITWORD);
  endfunction

  function automatic rtmc_act_e autoAction(input logic tx,
                                           input logic [4:0] code);
    rtmc_act_e a;
    a = RTMC_ACT_NONE;
    if (tx) begin
      unique case (code)
        `RTMC_MC_TXSTAT: a = RTMC_ACT_STATUS;
        `RTMC_MC_LASTCMD: a = RTMC_ACT_LASTCMD;
        `RTMC_MC_SHUT: a = RTMC_ACT_SHUT;
        `RTMC_MC_OVRD: a = RTMC_ACT_OVRD;
        `RTMC_MC_RESET: a = RTMC_ACT_RESET;
        default: a = RTMC_ACT_NONE;
      endcase
    end
    return a;
  endfunction

  assign bus.rt = bus.cmdWord[15:11];
  assign bus.isTx = bus.cmdWord[10];
  assign bus.sa = bus.cmdWord[9:5];
  assign bus.mc = bus.cmdWord[4:0];
  // subaddress 31 carries mode codes only under the newer revision
  assign bus.isMode = (bus.sa == `RTMC_SA_MODE0) ||
                      (bus.revB && bus.sa == `RTMC_SA_MODE31);
  assign bus.isBcast = bus.rt == `RTMC_RT_BCAST;
  assign bus.hasData = bus.mc[`RTMC_MC_DATA_BIT];
  assign bus.bcastOk = bcastAllowed(bus.mc);
  assign bus.act = autoAction(bus.isTx, bus.mc);
endmodule

/* File: testbench/rtmc_bc_model.sv */
// bus controller model that hands command words to the handler
`timescale 1ns/100ps
module rtmc_bc_model (
  // clock
  input wire logic clk_sys,
  // command words
  output logic cmdValid,
  output rtmc_pkg::rtmc_word_t cmdWord,
  output logic cmdBus
);
  import rtmc_pkg::*;
  initial begin
    cmdValid = 1'h0;
    cmdWord = 16'h0000;
    cmdBus = 1'h0;
  end
  // a broadcast simply uses terminal address 31 in the word
  task automatic issue(input rtmc_word_t w, input logic b);
    @(posedge clk_sys);
    cmdValid <= 1'h1;
    cmdWord <= w;
    cmdBus <= b;
    @(posedge clk_sys);
    cmdValid <= 1'h0;
    // word is stale outside the pulse, so show garbage
    cmdWord <= ~w;
    cmdBus <= ~b;
  endtask
endmodule

/* File: testbench/test_rt_mode_code_handler.sv */
// self-checking bench for the mode code handler
`timescale 1ns/100ps
`include "rtmc_defs.svh"
module test_rt_mode_code_handler;
  import rtmc_pkg::*;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, txEnA, txEnB, rd;
  logic cmdValid, cmdBus, rspValid, rspDataValid, rv, dv, er;
  rtmc_word_t cmdWord, rspStatus, rspData, st, dt;
  int failures = 0;
  int checks_done = 0;
  // transmit mode codes 1,2,4,5,8,16,18 on; 3 left off on purpose
  localparam logic [31:0] TXMASK = 32'h00050136;
  rtmc_handler i_dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmdValid(cmdValid), .cmdWord(cmdWord), .cmdBus(cmdBus),
    .rspValid(rspValid), .rspStatus(rspStatus),
    .rspDataValid(rspDataValid), .rspData(rspData), .txEnA(txEnA),
    .txEnB(txEnB), .irq(irq));
  rtmc_bc_model i_bc (.clk_sys(clk_sys), .cmdValid(cmdValid),
    .cmdWord(cmdWord), .cmdBus(cmdBus));
  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string name, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    chk("pready wait", n, 32'h1);
  endtask
  task automatic send(input logic [4:0] rt, input logic tr,
                      input logic [4:0] sa, mc, input logic bus);
    i_bc.issue({rt, tr, sa, mc}, bus);
    // response is a one-cycle pulse in the cycle after the command
    #1;
    rv = rspValid;
    dv = rspDataValid;
    st = rspStatus;
    dt = rspData;
  endtask
  task automatic cfg(input logic [4:0] rt, input logic [31:0] c);
    apb(1'h1, `RTMC_OFF_TERM_SEL, {27'h0, rt});
    apb(1'h1, `RTMC_OFF_TERM_CFG, c);
    apb(1'h1, `RTMC_OFF_TX_MC_EN, TXMASK);
    apb(1'h1, `RTMC_OFF_RX_MC_EN, 32'h00020000);
  endtask
  task automatic t_reset;
    chk("txEnA", txEnA, 32'hffffffff);
    chk("txEnB", txEnB, 32'hffffffff);
    chk("irq", irq, 1'h0);
    apb(1'h0, `RTMC_OFF_CTRL, 32'h0);
    chk("ctrl", rd, 32'h1);
    apb(1'h0, 12'h0fc, 32'h0);
    chk("pslverr", er, 1'h1);
    chk("unmapped", rd, 32'h0);
    cfg(5'd5, 32'h1);
    cfg(5'd31, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_status;
    // a status word must have gone out before one can be returned
    send(5'd5, 1'h1, 5'd0, 5'h01, 1'h0);
    chk("sw rsp", rv, 1'h1);
    send(5'd5, 1'h1, 5'd0, 5'h02, 1'h0);
    chk("rspValid", rv, 1'h1);
    chk("status word", st, 16'h2800);
    chk("status rt", st[15:11], 5'd5);
    chk("status bc", st[4], 1'h0);
    chk("no data", dv, 1'h0);
    send(5'd5, 1'h1, 5'd31, 5'h02, 1'h0);
    chk("sa31 rsp", rv, 1'h1);
    send(5'd5, 1'h1, 5'd0, 5'h03, 1'h0);
    chk("disabled code", rv, 1'h0);
    send(5'd5, 1'h0, 5'd0, 5'h11, 1'h0);
    chk("rx code on", rv, 1'h1);
    send(5'd5, 1'h0, 5'd0, 5'h01, 1'h0);
    chk("rx code off", rv, 1'h0);
    $display("test status done");
  endtask
  task automatic t_lastcmd;
    send(5'd31, 1'h1, 5'd0, 5'h01, 1'h0);
    chk("bcast no rsp", rv, 1'h0);
    send(5'd5, 1'h1, 5'd0, 5'h12, 1'h1);
    chk("rspValid", rv, 1'h1);
    chk("data valid", dv, 1'h1);
    chk("bc bit", st[4], 1'h1);
    chk("last cmd", dt, 16'hfc01);
    send(5'd5, 1'h1, 5'd0, 5'h12, 1'h1);
    chk("bc bit cleared", st[4], 1'h0);
    chk("last cmd own", dt, 16'h2811);
    send(5'd31, 1'h1, 5'd0, 5'h01, 1'h0);
    send(5'd5, 1'h1, 5'd0, 5'h02, 1'h0);
    chk("status bc bit", st[4], 1'h1);
    $display("test last command done");
  endtask
  task automatic t_shut;
    send(5'd5, 1'h1, 5'd0, 5'h04, 1'h0);
    chk("shut B", txEnB, 32'hffffffdf);
    chk("shut A", txEnA, 32'hffffffff);
    send(5'd5, 1'h1, 5'd0, 5'h05, 1'h0);
    chk("override", txEnB, 32'hffffffff);
    send(5'd31, 1'h1, 5'd0, 5'h04, 1'h0);
    chk("bshut 5", txEnB[5], 1'h0);
    chk("bshut 31", txEnB[31], 1'h0);
    send(5'd31, 1'h1, 5'd0, 5'h05, 1'h0);
    chk("boverride", txEnB[5], 1'h1);
    send(5'd5, 1'h1, 5'd0, 5'h04, 1'h1);
    chk("shut A by B", txEnA[5], 1'h0);
    send(5'd31, 1'h1, 5'd0, 5'h08, 1'h0);
    chk("breset A", txEnA[5], 1'h1);
    chk("breset B", txEnB[5], 1'h1);
    send(5'd5, 1'h1, 5'd0, 5'h04, 1'h1);
    chk("shut A again", txEnA[5], 1'h0);
    send(5'd5, 1'h1, 5'd0, 5'h08, 1'h0);
    chk("reset A", txEnA[5], 1'h1);
    chk("reset B", txEnB[5], 1'h1);
    $display("test shutdown done");
  endtask
  task automatic t_soft;
    apb(1'h0, `RTMC_OFF_IRQ_STAT, 32'h0);
    apb(1'h1, `RTMC_OFF_IRQ_MASK, 32'h1);
    send(5'd5, 1'h1, 5'd0, 5'h01, 1'h0);
    #5;
    chk("irq raised", irq, 1'h1);
    apb(1'h0, `RTMC_OFF_SW_CMD, 32'h0);
    chk("sw cmd", rd, 32'h2c01);
    apb(1'h0, `RTMC_OFF_IRQ_STAT, 32'h0);
    chk("stat sw", rd[0], 1'h1);
    @(negedge clk_sys);
    chk("irq cleared", irq, 1'h0);
    apb(1'h1, `RTMC_OFF_IRQ_MASK, 32'h0);
    send(5'd31, 1'h1, 5'd0, 5'h02, 1'h0);
    #5;
    chk("masked", irq, 1'h0);
    apb(1'h0, `RTMC_OFF_IRQ_STAT, 32'h0);
    chk("bad bcast", rd[2], 1'h1);
    $display("test software done");
  endtask
  task automatic t_busy;
    apb(1'h1, `RTMC_OFF_TERM_SEL, 32'h5);
    apb(1'h1, `RTMC_OFF_STS_BASE, 32'h8);
    send(5'd5, 1'h1, 5'd0, 5'h12, 1'h0);
    chk("busy rsp", rv, 1'h1);
    chk("busy no data", dv, 1'h0);
    apb(1'h1, `RTMC_OFF_STS_BASE, 32'h0);
    cfg(5'd5, 32'h3);
    send(5'd5, 1'h1, 5'd0, 5'h04, 1'h0);
    chk("mailbox", txEnB[5], 1'h1);
    $display("test busy done");
  endtask
  task automatic t_reva;
    cfg(5'd5, 32'h1);
    apb(1'h1, `RTMC_OFF_CTRL, 32'h0);
    apb(1'h0, `RTMC_OFF_IRQ_STAT, 32'h0);
    send(5'd5, 1'h1, 5'd31, 5'h01, 1'h0);
    apb(1'h0, `RTMC_OFF_IRQ_STAT, 32'h0);
    chk("sa31 ignored", rd[0], 1'h0);
    send(5'd5, 1'h1, 5'd0, 5'h01, 1'h0);
    apb(1'h0, `RTMC_OFF_IRQ_STAT, 32'h0);
    chk("sa0 taken", rd[0], 1'h1);
    $display("test older revision done");
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    rstn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'h1;
    t_reset;
    t_status;
    t_lastcmd;
    t_shut;
    t_soft;
    t_busy;
    t_reva;
    complete_run;
  end
  // whole run is under two hundred cycles; this is far beyond it
  initial begin
    #100000;
    failures++;
    complete_run;
  end
endmodule
